// *** verilog/acp_pkg.sv ***
// holds the register map, field layout and shared types of the
// clock and pattern configuration register block.
// assumes a single 100 MHz clock and a serial control port master.

package acp_pkg;

  // register addresses
  localparam logic [6:0] ADDR_PLL_CTRL = 7'h08;
  localparam logic [6:0] ADDR_PLL_RB = 7'h09;
  localparam logic [6:0] ADDR_CLK_CFG = 7'h0a;
  localparam logic [6:0] ADDR_CLK_RB = 7'h0b;
  localparam logic [6:0] ADDR_PAT_LO = 7'h10;
  localparam logic [6:0] ADDR_PAT_LO_RB = 7'h11;
  localparam logic [6:0] ADDR_PAT_HI = 7'h12;
  localparam logic [6:0] ADDR_PAT_HI_RB = 7'h13;

  // reset value of every writable register, and read value of unmapped addresses
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // pll control field positions
  localparam int PLL_CAL_BIT = 0;
  localparam int PLL_BW_BIT = 1;

  // clock register field positions
  localparam int CLK_HYS_ALL_OFF_BIT = 0;
  localparam int CLK_HYS_DEF_OFF_BIT = 1;
  localparam int CLK_HYS_SMALL_BIT = 2;
  localparam int CLK_HYS_MEDIUM_BIT = 3;
  localparam int CLK_HYS_LARGE_BIT = 4;
  localparam int CLK_INV_BIT = 5;

  // pattern layout
  localparam int PAT_W = 12;
  localparam int PAT_HI_W = 4;
  localparam logic [1:0] TRAIN_SEL_CUSTOM = 2'h3;
  localparam logic [PAT_W-1:0] PAT_IDLE = 12'h000;

  // serial frame: r/w flag, 7 address bits, 8 data bits
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS_END = 8;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h08;
  localparam logic [4:0] CNT_FRAME_DONE = 5'h10;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam int RW_BIT = 7;

  // number of pins passed through the synchroniser
  localparam int SYNC_W = 4;

  // frame state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_DONE = 2'b11
  } acp_state_t;

  // hysteresis that the clock input buffer applies
  typedef enum logic [2:0] {
    HYS_10MV = 3'b000,
    HYS_NONE = 3'b001,
    HYS_20MV = 3'b010,
    HYS_50MV = 3'b011,
    HYS_100MV = 3'b100
  } acp_hys_t;

  // decoded serial command
  typedef struct packed {
    logic rd;
    logic [6:0] addr;
  } acp_cmd_t;

  // stored configuration bytes
  typedef struct packed {
    logic [7:0] pll;
    logic [7:0] clk;
    logic [7:0] pat_lo;
    logic [7:0] pat_hi;
  } acp_regs_t;

endpackage

// *** verilog/acp_sync.sv ***
// holds a two flip-flop synchroniser for a group of pin inputs.
// assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps

module acp_sync #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [W-1:0] async_in, // raw pin levels
  input wire logic [W-1:0] rst_val, // level held during reset
  output logic [W-1:0] sync_out // synchronised levels
);

  // one pair of flops per pin; stage one feeds only stage two
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_ff;
      logic stab_ff;
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          meta_ff <= rst_val[gi];
          stab_ff <= rst_val[gi];
        end else begin
          meta_ff <= async_in[gi];
          stab_ff <= meta_ff;
        end
      end
      assign sync_out[gi] = stab_ff;
    end
  endgenerate

endmodule // acp_sync

// *** verilog/acp_regs.sv ***
// holds the serial-port register bank for pll control, input clock
// hysteresis and the custom training pattern.
// assumes a mode 0 serial master (sample on rising sclk, msb first)
// running far slower than clk, and a lock flag from the pll.
`timescale 1ns/1ps

module acp_regs
  import acp_pkg::*;
(
  input wire logic clk, // 100 MHz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic spi_sclk, // serial clock pin
  input wire logic spi_cs_n, // chip select pin, active low
  input wire logic spi_mosi, // serial data in pin
  output logic spi_miso, // serial data out
  output logic spi_miso_oe, // miso drive enable, high drives
  input wire logic pll_locked, // pll lock flag, asynchronous
  input wire logic [1:0] train_seq_sel, // decimator training select
  output logic loop_wide_band_sel, // 1 selects high loop bandwidth
  output logic osc_cal_restart, // one-cycle calibration trigger
  output logic ref_clock_polarity_flip, // 1 inverts reference clock
  output acp_hys_t hyst_mode, // hysteresis applied to clock input
  output logic [PAT_W-1:0] train_pattern, // pattern to serializer
  output logic train_pattern_valid // custom pattern selected
);

  // synchronised pins
  logic [SYNC_W-1:0] pins_sync;
  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;
  logic lock_s;

  // edge detection history
  logic sclk_prev_ff;
  logic lock_prev_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic lock_lost;

  // frame state
  acp_state_t state_ff;
  acp_state_t nxt_state;
  logic [4:0] bit_cnt_ff;
  logic [FRAME_BITS-1:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic [7:0] rd_data;
  acp_cmd_t cmd;
  acp_cmd_t cmd_ff;
  logic frame_write;

  // stored configuration
  acp_regs_t regs_ff;
  logic cal_write;

  // output flops
  logic miso_ff;
  logic miso_oe_ff;
  logic bw_ff;
  logic cal_pulse_ff;
  logic inv_ff;
  acp_hys_t hys_ff;
  acp_hys_t nxt_hys;
  logic [PAT_W-1:0] pat_out_ff;
  logic pat_valid_ff;
  logic [PAT_W-1:0] pat_word;

  // all pins from outside pass two flops first
  // chip select rests high, every other pin low
  acp_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({pll_locked, spi_mosi, spi_cs_n, spi_sclk}),
    .rst_val(4'h2),
    .sync_out(pins_sync)
  );

  assign sclk_s = pins_sync[0];
  assign cs_n_s = pins_sync[1];
  assign mosi_s = pins_sync[2];
  assign lock_s = pins_sync[3];

  // previous levels for edge detection
  // both start at the idle level, so reset makes no false edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_prev_ff <= 1'b0;
      lock_prev_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sclk_s;
      lock_prev_ff <= lock_s;
    end
  end

  // serial clock edges count only inside a selected frame
  // a lock drop is a falling level of the synchronised flag
  assign sclk_rise = ~cs_n_s & sclk_s & ~sclk_prev_ff;
  assign sclk_fall = ~cs_n_s & ~sclk_s & sclk_prev_ff;
  assign lock_lost = lock_prev_ff & ~lock_s;

  // command byte held for the whole data phase; the shift register
  // keeps moving and would otherwise turn data bits into the command
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_ff <= '0;
    end else if (state_ff == ST_ADDR && sclk_rise &&
                 bit_cnt_ff == 5'(ADDR_BITS_END - 1)) begin
      cmd_ff <= {rx_sh_ff[RW_BIT-1:0], mosi_s};
    end
  end
  assign cmd = cmd_ff;

  // frame state machine
  // eighth rise ends the command byte, sixteenth ends the frame
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (!cs_n_s) begin
          nxt_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (cs_n_s) begin
          nxt_state = ST_IDLE;
        end else if (sclk_rise && bit_cnt_ff == 5'(ADDR_BITS_END - 1)) begin
          nxt_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (cs_n_s) begin
          nxt_state = ST_IDLE;
        end else if (sclk_rise && bit_cnt_ff == 5'(FRAME_BITS - 1)) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        // extra clocks after the frame are ignored
        if (cs_n_s) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // bit counter, cleared whenever chip select drops the frame
  // holds at sixteen so late edges cannot wrap it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt_ff <= CNT_ZERO;
    end else if (cs_n_s || state_ff == ST_IDLE) begin
      bit_cnt_ff <= CNT_ZERO;
    end else if (sclk_rise && state_ff != ST_DONE) begin
      bit_cnt_ff <= bit_cnt_ff + CNT_ONE;
    end
  end

  // receive shift register, msb first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_sh_ff <= '0;
    end else if (sclk_rise && state_ff != ST_DONE) begin
      rx_sh_ff <= {rx_sh_ff[FRAME_BITS-2:0], mosi_s};
    end
  end

  // a write completes on the last rising edge of a full frame
  // a frame cut short never reaches this point, so nothing is written
  assign frame_write = sclk_rise && state_ff == ST_DATA &&
                       bit_cnt_ff == 5'(FRAME_BITS - 1) &&
                       !rx_sh_ff[FRAME_BITS-2];

  // read data: only the odd readback addresses answer
  // the writable addresses themselves read as zero
  always_comb begin
    case (cmd.addr)
      ADDR_PLL_RB: rd_data = regs_ff.pll;
      ADDR_CLK_RB: rd_data = regs_ff.clk;
      ADDR_PAT_LO_RB: rd_data = regs_ff.pat_lo;
      ADDR_PAT_HI_RB: rd_data = regs_ff.pat_hi;
      default: rd_data = RD_UNMAPPED;
    endcase
  end

  // transmit shift register, loaded once the address byte is in
  // bit 7 goes straight to miso_ff, so only bits 6:0 are kept here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_sh_ff <= RD_UNMAPPED;
    end else if (state_ff == ST_DATA && bit_cnt_ff == CNT_ADDR_DONE &&
                 sclk_fall) begin
      tx_sh_ff <= {rd_data[6:0], 1'b0};
    end else if (state_ff == ST_DATA && sclk_fall) begin
      tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
    end
  end

  // miso changes on falling sclk so the master samples it on rising
  // held low outside the data phase so a released line reads zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      miso_ff <= 1'b0;
    end else if (cs_n_s || state_ff != ST_DATA) begin
      miso_ff <= 1'b0;
    end else if (sclk_fall && bit_cnt_ff == CNT_ADDR_DONE) begin
      miso_ff <= cmd.rd ? rd_data[7] : 1'b0;
    end else if (sclk_fall) begin
      miso_ff <= cmd.rd ? tx_sh_ff[7] : 1'b0;
    end
  end

  // drive miso only during the data phase of a read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      miso_oe_ff <= 1'b0;
    end else begin
      miso_oe_ff <= state_ff == ST_DATA && !cs_n_s && cmd.rd &&
                    bit_cnt_ff >= CNT_ADDR_DONE &&
                    bit_cnt_ff < CNT_FRAME_DONE;
    end
  end

  // the address of a write sits in bits 13:7 at the last rising edge of the frame
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  assign wr_addr = rx_sh_ff[FRAME_BITS-3:FRAME_BITS-9];
  assign wr_data = {rx_sh_ff[6:0], mosi_s};

  // writable registers; reserved bits stored as written
  // readback and unmapped addresses fall through untouched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regs_ff.pll <= REG_RESET;
      regs_ff.clk <= REG_RESET;
      regs_ff.pat_lo <= REG_RESET;
      regs_ff.pat_hi <= REG_RESET;
    end else if (frame_write) begin
      case (wr_addr)
        ADDR_PLL_CTRL: regs_ff.pll <= wr_data;
        ADDR_CLK_CFG: regs_ff.clk <= wr_data;
        ADDR_PAT_LO: regs_ff.pat_lo <= wr_data;
        ADDR_PAT_HI: regs_ff.pat_hi <= wr_data;
        default: ;
      endcase
    end
  end

  // a write with the calibration bit set, seen once per write
  assign cal_write = frame_write && wr_addr == ADDR_PLL_CTRL &&
                     wr_data[PLL_CAL_BIT];

  // calibration trigger: single pulse per write or per lock loss
  // follows the write strobe, not the stored bit, so it cannot repeat
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal_pulse_ff <= 1'b0;
    end else begin
      cal_pulse_ff <= cal_write || lock_lost;
    end
  end

  // loop bandwidth select follows the stored bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bw_ff <= 1'b0;
    end else begin
      bw_ff <= regs_ff.pll[PLL_BW_BIT];
    end
  end

  // reference clock polarity follows the stored bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inv_ff <= 1'b0;
    end else begin
      inv_ff <= regs_ff.clk[CLK_INV_BIT];
    end
  end

  // hysteresis decode; all-off wins, then largest setting wins
  // software is expected to set one bit; overlaps still decode
  always_comb begin
    nxt_hys = HYS_10MV;
    if (regs_ff.clk[CLK_HYS_ALL_OFF_BIT]) begin
      nxt_hys = HYS_NONE;
    end else if (regs_ff.clk[CLK_HYS_LARGE_BIT]) begin
      nxt_hys = HYS_100MV;
    end else if (regs_ff.clk[CLK_HYS_MEDIUM_BIT]) begin
      nxt_hys = HYS_50MV;
    end else if (regs_ff.clk[CLK_HYS_SMALL_BIT]) begin
      nxt_hys = HYS_20MV;
    end else if (regs_ff.clk[CLK_HYS_DEF_OFF_BIT]) begin
      nxt_hys = HYS_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hys_ff <= HYS_10MV;
    end else begin
      hys_ff <= nxt_hys;
    end
  end

  // twelve-bit pattern from the two pattern registers
  assign pat_word = {regs_ff.pat_hi[PAT_HI_W-1:0],
                     regs_ff.pat_lo};

  // pattern goes out only while training sequence 3 is selected
  // idle pattern otherwise keeps the serializer input quiet
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pat_out_ff <= PAT_IDLE;
      pat_valid_ff <= 1'b0;
    end else if (train_seq_sel == TRAIN_SEL_CUSTOM) begin
      pat_out_ff <= pat_word;
      pat_valid_ff <= 1'b1;
    end else begin
      pat_out_ff <= PAT_IDLE;
      pat_valid_ff <= 1'b0;
    end
  end

  // outputs straight from flops
  // no logic between the registers and the ports
  assign spi_miso = miso_ff;
  assign spi_miso_oe = miso_oe_ff;
  assign loop_wide_band_sel = bw_ff;
  assign osc_cal_restart = cal_pulse_ff;
  assign ref_clock_polarity_flip = inv_ff;
  assign hyst_mode = hys_ff;
  assign train_pattern = pat_out_ff;
  assign train_pattern_valid = pat_valid_ff;

endmodule // acp_regs

// *** test/acp_regs_properties.sv ***
// concurrent checks on the ports of the clock and pattern register bank.
// assumes it is bound to acp_regs and sees only that module's ports.
`timescale 1ns/1ps

module acp_regs_properties
  import acp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic spi_sclk, // serial clock pin
  input wire logic spi_cs_n, // chip select pin, active low
  input wire logic spi_mosi, // serial data in pin
  input wire logic spi_miso, // serial data out
  input wire logic spi_miso_oe, // miso drive enable
  input wire logic pll_locked, // pll lock flag
  input wire logic [1:0] train_seq_sel, // training select
  input wire logic loop_wide_band_sel, // loop bandwidth select
  input wire logic osc_cal_restart, // calibration trigger
  input wire logic ref_clock_polarity_flip, // clock inversion
  input wire acp_hys_t hyst_mode, // hysteresis mode
  input wire logic [PAT_W-1:0] train_pattern, // pattern out
  input wire logic train_pattern_valid // pattern selected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // port deselected long enough for the synchroniser to settle
  sequence cs_idle_s;
    spi_cs_n [*6];
  endsequence
  // lock lost at the pin
  sequence lock_drop_s;
    $fell(pll_locked);
  endsequence

  // calibration trigger lasts one cycle only
  a_cal_one_pulse: assert property (
    osc_cal_restart |=> !osc_cal_restart)
    else $error("calibration trigger longer than one cycle");
  // lost lock starts calibration by itself
  a_cal_lock_loss: assert property (
    lock_drop_s |-> ##[1:6] osc_cal_restart)
    else $error("no calibration after lock loss");
  // custom select raises the valid flag next cycle
  a_seq_custom: assert property (
    train_seq_sel == TRAIN_SEL_CUSTOM |=> train_pattern_valid)
    else $error("custom pattern not selected");
  // any other select gives idle pattern
  a_seq_other: assert property (
    train_seq_sel != TRAIN_SEL_CUSTOM |=>
    !train_pattern_valid && train_pattern == PAT_IDLE)
    else $error("pattern shown while not selected");
  // pattern steady while the port is quiet
  a_pat_steady: assert property (
    cs_idle_s ##0 train_pattern_valid ##1
    train_pattern_valid |-> $stable(train_pattern))
    else $error("pattern changed without a write");
  // miso low when not driven
  a_miso_quiet: assert property (
    !spi_miso_oe |-> !spi_miso)
    else $error("miso high while not driven");
  // drive released once deselected
  a_oe_release: assert property (
    cs_idle_s |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  // configuration changes only through a frame
  a_cfg_stable: assert property (
    cs_idle_s ##1 spi_cs_n |->
    $stable(loop_wide_band_sel) && $stable(ref_clock_polarity_flip) &&
    $stable(hyst_mode))
    else $error("configuration changed without a write");
  // outputs at their reset state on release
  a_reset_clear: assert property (
    $fell(sys_rst) |-> !loop_wide_band_sel &&
    !osc_cal_restart && !ref_clock_polarity_flip &&
    hyst_mode == HYS_10MV && !train_pattern_valid)
    else $error("outputs not cleared by reset");
endmodule // acp_regs_properties

bind acp_regs acp_regs_properties chk_u (
  .clk(clk),
  .sys_rst(sys_rst),
  .spi_sclk(spi_sclk),
  .spi_cs_n(spi_cs_n),
  .spi_mosi(spi_mosi),
  .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe),
  .pll_locked(pll_locked),
  .train_seq_sel(train_seq_sel),
  .loop_wide_band_sel(loop_wide_band_sel),
  .osc_cal_restart(osc_cal_restart),
  .ref_clock_polarity_flip(ref_clock_polarity_flip),
  .hyst_mode(hyst_mode),
  .train_pattern(train_pattern),
  .train_pattern_valid(train_pattern_valid)
);

// *** test/acp_regs_tb.sv ***
// self-checking bench for the clock and pattern register bank.
// assumes the checker is bound in and a 100 MHz clock.
`timescale 1ns/1ps

module acp_regs_tb;
  import acp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic spi_sclk = 1'b0;
  logic spi_cs_n = 1'b1;
  logic spi_mosi = 1'b0;
  logic pll_locked = 1'b0;
  logic [1:0] train_seq_sel = 2'h0;
  logic spi_miso, spi_miso_oe, loop_wide_band_sel, osc_cal_restart;
  logic ref_clock_polarity_flip, train_pattern_valid;
  acp_hys_t hyst_mode;
  logic [PAT_W-1:0] train_pattern;
  logic [7:0] rd;
  int n_fail = 0;
  int checks = 0;
  int cal_cnt = 0;
  logic [6:0] rbk [4] = '{ADDR_PLL_RB, ADDR_CLK_RB, ADDR_PAT_LO_RB,
    ADDR_PAT_HI_RB};
  logic [7:0] ctab [9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
    8'h20, 8'h1e, 8'h0c};

  // 100 MHz clock
  always #5 clk = ~clk;

  acp_regs dut_u (
    .clk(clk),
    .sys_rst(sys_rst),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .pll_locked(pll_locked),
    .train_seq_sel(train_seq_sel),
    .loop_wide_band_sel(loop_wide_band_sel),
    .osc_cal_restart(osc_cal_restart),
    .ref_clock_polarity_flip(ref_clock_polarity_flip),
    .hyst_mode(hyst_mode),
    .train_pattern(train_pattern),
    .train_pattern_valid(train_pattern_valid)
  );

  // count calibration pulses
  always @(posedge clk) begin
    if (osc_cal_restart === 1'b1) cal_cnt <= cal_cnt + 1;
  end

  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one frame, msb first, sclk half period 8 clocks; nb < 16 aborts
  task automatic frame(input logic [15:0] w, input int nb,
    output logic [7:0] r);
    spi_cs_n = 1'b0;
    tick(8);
    for (int i = 15; i > 15 - nb; i--) begin
      spi_mosi = w[i];
      tick(8);
      spi_sclk = 1'b1;
      if (i < 8) r[i] = spi_miso;
      if (i < 8 && w[15]) chk(spi_miso_oe, 1'b1);
      tick(8);
      spi_sclk = 1'b0;
    end
    tick(16);
    spi_cs_n = 1'b1;
    tick(8);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    frame({1'b0, a, d}, 16, rd);
  endtask

  task automatic rb(input logic [6:0] a, input logic [7:0] e);
    frame({1'b1, a, 8'h00}, 16, rd);
    chk(rd, e);
  endtask

  // hysteresis expected from the clock register byte
  function automatic acp_hys_t hexp(input logic [7:0] v);
    return v[0] ? HYS_NONE : v[4] ? HYS_100MV : v[3] ? HYS_50MV :
      v[2] ? HYS_20MV : v[1] ? HYS_NONE : HYS_10MV;
  endfunction

  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // cut a hang short, about five times the expected run
  initial begin
    #500000;
    n_fail++;
    close_out();
  end

  // main sequence
  initial begin
    tick(10);
    sys_rst = 1'b0;
    tick(4);
    chk(hyst_mode, HYS_10MV);
    foreach (rbk[i]) rb(rbk[i], 8'h00);
    $display("test reset done");
    cal_cnt = 0;
    wr(ADDR_PLL_CTRL, 8'h03);
    chk(cal_cnt, 1);
    chk(loop_wide_band_sel, 1'b1);
    rb(ADDR_PLL_RB, 8'h03);
    wr(ADDR_PLL_CTRL, 8'h01);
    chk(cal_cnt, 2);
    chk(loop_wide_band_sel, 1'b0);
    wr(ADDR_PLL_CTRL, 8'h02);
    chk(cal_cnt, 2);
    wr(ADDR_PLL_RB, 8'h55);
    rb(ADDR_PLL_RB, 8'h02);
    rb(ADDR_PLL_CTRL, 8'h00);
    wr(7'h7f, 8'haa);
    rb(7'h7f, 8'h00);
    $display("test pll done");
    foreach (ctab[i]) begin
      wr(ADDR_CLK_CFG, ctab[i]);
      chk(hyst_mode, hexp(ctab[i]));
      chk(ref_clock_polarity_flip, ctab[i][5]);
      rb(ADDR_CLK_RB, ctab[i]);
    end
    frame({1'b0, ADDR_CLK_CFG, 8'h3f}, 12, rd);
    rb(ADDR_CLK_RB, 8'h0c);
    $display("test clock done");
    wr(ADDR_PAT_LO, 8'ha5);
    wr(ADDR_PAT_HI, 8'h03);
    rb(ADDR_PAT_LO_RB, 8'ha5);
    rb(ADDR_PAT_HI_RB, 8'h03);
    for (int s = 0; s < 4; s++) begin
      train_seq_sel = s[1:0];
      tick(2);
      chk(train_pattern_valid, s == 3);
      chk(train_pattern, s == 3 ? 12'h3a5 : PAT_IDLE);
    end
    train_seq_sel = 2'h0;
    $display("test pattern done");
    cal_cnt = 0;
    pll_locked = 1'b1;
    tick(10);
    pll_locked = 1'b0;
    tick(10);
    chk(cal_cnt, 1);
    $display("test lock done");
    sys_rst = 1'b1;
    tick(10);
    sys_rst = 1'b0;
    tick(4);
    chk(loop_wide_band_sel, 1'b0);
    rb(ADDR_PAT_LO_RB, 8'h00);
    $display("test second reset done");
    close_out();
  end
endmodule // acp_regs_tb
